// ### tb/pin_check_and_replace_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module pin_check_and_replace_tb_top;
  localparam logic [63:0] CODE_A = 64'h1234_5678_9ABC_DEF0;
  localparam logic [63:0] CODE_B = 64'h0FED_CBA9_8765_4321;
  localparam int          CEIL   = 3000;
  localparam pin_check_pkg::op_t CHK = pin_check_pkg::OP_CHECK;
  localparam pin_check_pkg::op_t REP = pin_check_pkg::OP_REPLACE;
  localparam pin_check_pkg::op_t ACC = pin_check_pkg::OP_ACCESS;

  logic                   ref_clk;
  logic                   rst_n;
  logic                   cmdValid;
  pin_check_pkg::cmd_t    cmdIn;
  logic                   cmdReady_ff;
  logic                   persoValid;
  logic [4:0]             persoRef;
  pin_check_pkg::keyRec_t persoRec;
  logic                   rspValid_ff;
  logic [15:0]            rspSw_ff;
  logic [31:0]            securityOk_ff;
  int                     err_total;
  int                     n_compared;
  int                     cycles;

  pin_check_and_replace #(.NUM_KEYS(32)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdIn(cmdIn),
    .cmdReady_ff(cmdReady_ff), .persoValid(persoValid), .persoRef(persoRef),
    .persoRec(persoRec), .rspValid_ff(rspValid_ff), .rspSw_ff(rspSw_ff),
    .securityOk_ff(securityOk_ff)
  );

  term_model term_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdIn(cmdIn),
    .cmdReady_ff(cmdReady_ff), .rspValid_ff(rspValid_ff), .rspSw_ff(rspSw_ff)
  );

  always #10 ref_clk = ~ref_clk;

  task automatic close_out();
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard: a stuck handshake must still end in the verdict
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == CEIL) begin
      err_total++;
      $display("ERROR at %0t: run did not finish", $time);
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input pin_check_pkg::op_t op, input logic [7:0] p2, input logic [7:0] lc,
                     input logic [63:0] a, input logic [63:0] b, input logic [15:0] exp,
                     input logic [7:0] p1 = 8'h00);
    logic [15:0] sw;
    logic        ok;
    term_u.issue(pin_check_pkg::cmd_t'{op, p1, p2, lc, {a, b}}, sw, ok);
    check({31'h0, ok}, 32'h1);
    check({16'h0, sw}, {16'h0, exp});
  endtask

  task automatic perso(input logic [4:0] r, input logic dis, input logic [63:0] c);
    int n;
    n = 0;
    @(negedge ref_clk);
    persoValid <= 1'b1;
    persoRef   <= r;
    persoRec   <= {dis, 2'h3, c};
    while (cmdReady_ff !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    persoValid <= 1'b0;
    persoRef   <= ~r;
    persoRec   <= ~{dis, 2'h3, c};
  endtask

  task automatic sc_block();
    perso(5'h01, 1'b0, CODE_A);
    cmd(CHK, 8'h01, 8'h08, CODE_B, 64'h0, 16'h63C2);
    cmd(CHK, 8'h01, 8'h08, CODE_B, 64'h0, 16'h63C1);
    cmd(CHK, 8'h01, 8'h08, CODE_B, 64'h0, 16'h63C0);
    cmd(CHK, 8'h01, 8'h08, CODE_A, 64'h0, 16'h6983);
    cmd(CHK, 8'h01, 8'h00, 64'h0, 64'h0, 16'h63C0);
    cmd(ACC, 8'h01, 8'h00, 64'h0, 64'h0, 16'h6982);
    cmd(REP, 8'h01, 8'h10, CODE_A, CODE_B, 16'h6983);
  endtask

  task automatic sc_good();
    perso(5'h02, 1'b0, CODE_A);
    cmd(CHK, 8'h02, 8'h08, CODE_A, 64'h0, 16'h9000);
    check({31'h0, securityOk_ff[2]}, 32'h1);
    cmd(CHK, 8'h02, 8'h08, CODE_B, 64'h0, 16'h63C2);
    cmd(CHK, 8'h02, 8'h08, CODE_A, 64'h0, 16'h9000);
    cmd(CHK, 8'h02, 8'h00, 64'h0, 64'h0, 16'h63C3);
  endtask

  task automatic sc_replace();
    perso(5'h03, 1'b0, CODE_A);
    cmd(REP, 8'h03, 8'h10, CODE_B, CODE_B, 16'h63C2);
    cmd(CHK, 8'h03, 8'h08, CODE_B, 64'h0, 16'h63C1);
    cmd(REP, 8'h03, 8'h10, CODE_A, CODE_B, 16'h9000);
    cmd(CHK, 8'h03, 8'h00, 64'h0, 64'h0, 16'h63C3);
    cmd(CHK, 8'h03, 8'h08, CODE_B, 64'h0, 16'h9000);
    cmd(REP, 8'h03, 8'h08, CODE_B, CODE_A, 16'h6700);
  endtask

  task automatic sc_disabled();
    perso(5'h04, 1'b1, CODE_A);
    cmd(CHK, 8'h04, 8'h08, CODE_A, 64'h0, 16'h6984);
    cmd(CHK, 8'h04, 8'h00, 64'h0, 64'h0, 16'h63C3);
    cmd(ACC, 8'h04, 8'h00, 64'h0, 64'h0, 16'h9000);
    cmd(REP, 8'h04, 8'h10, CODE_A, CODE_B, 16'h6984);
  endtask

  task automatic sc_access();
    perso(5'h07, 1'b0, CODE_A);
    cmd(ACC, 8'h07, 8'h00, 64'h0, 64'h0, 16'h6982);
    cmd(CHK, 8'h07, 8'h08, CODE_A, 64'h0, 16'h9000);
    cmd(ACC, 8'h07, 8'h00, 64'h0, 64'h0, 16'h9000);
  endtask

  task automatic sc_params();
    perso(5'h05, 1'b0, CODE_A);
    cmd(CHK, 8'h00, 8'h08, CODE_A, 64'h0, 16'h6A86);
    cmd(CHK, 8'h25, 8'h08, CODE_B, 64'h0, 16'h6A86);
    cmd(REP, 8'h45, 8'h10, CODE_B, CODE_B, 16'h6A86);
    cmd(CHK, 8'h05, 8'h08, CODE_B, 64'h0, 16'h6A86, 8'h01);
    cmd(CHK, 8'h05, 8'h05, CODE_B, 64'h0, 16'h6700);
    cmd(CHK, 8'h05, 8'h00, 64'h0, 64'h0, 16'h63C3);
    cmd(CHK, 8'h85, 8'h08, CODE_A, 64'h0, 16'h9000);
    check({31'h0, securityOk_ff[5]}, 32'h1);
    cmd(CHK, 8'h05, 8'h08, CODE_B, 64'h0, 16'h63C2);
  endtask

  // Store is non-volatile: tries must survive a reset in mid-run
  task automatic sc_retain();
    perso(5'h06, 1'b0, CODE_A);
    cmd(CHK, 8'h06, 8'h08, CODE_B, 64'h0, 16'h63C2);
    @(negedge ref_clk);
    rst_n <= 1'b0;
    repeat (5) @(negedge ref_clk);
    check(securityOk_ff, 32'h0);
    rst_n <= 1'b1;
    cmd(CHK, 8'h06, 8'h00, 64'h0, 64'h0, 16'h63C2);
    cmd(CHK, 8'h06, 8'h08, CODE_B, 64'h0, 16'h63C1);
  endtask

  initial begin
    ref_clk    = 1'b0;
    rst_n      = 1'b0;
    persoValid = 1'b0;
    persoRef   = '0;
    persoRec   = '0;
    err_total  = 0;
    n_compared = 0;
    cycles     = 0;
    repeat (5) @(negedge ref_clk);
    rst_n <= 1'b1;
    sc_block();
    sc_good();
    sc_replace();
    sc_disabled();
    sc_access();
    sc_params();
    sc_retain();
    close_out();
  end
endmodule
`default_nettype wire

// ### tb/term_model.sv
`timescale 1ns/1ns
`default_nettype none
module term_model (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // Command side
  output var  logic                cmdValid,
  output var  pin_check_pkg::cmd_t cmdIn,
  input  wire logic                cmdReady_ff,
  // Answer side
  input  wire logic                rspValid_ff,
  input  wire logic [15:0]         rspSw_ff
);
  initial begin
    cmdValid = 1'b0;
    cmdIn    = '0;
  end

  // Released lines show the inverse so a stale value never passes for a held one
  task automatic issue(input pin_check_pkg::cmd_t c, output logic [15:0] sw, output logic ok);
    int n;
    n = 0;
    @(negedge ref_clk);
    cmdValid <= 1'b1;
    cmdIn    <= c;
    while (cmdReady_ff !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    cmdValid <= 1'b0;
    cmdIn    <= ~c;
    n = 0;
    while (rspValid_ff !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    sw = rspSw_ff;
    ok = (rspValid_ff === 1'b1);
  endtask
endmodule
`default_nettype wire

// ### verilog/code_store.sv
`timescale 1ns/1ns
`default_nettype none
module code_store #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // Read port
  input  wire logic                   rdEn,
  input  wire logic [AW-1:0]          rdAddr,
  output var  pin_check_pkg::keyRec_t rdData_ff,
  // Write port
  input  wire logic                   wrEn,
  input  wire logic [AW-1:0]          wrAddr,
  input  wire pin_check_pkg::keyRec_t wrData
);

  // Stands in for non-volatile cells: no reset, so tries outlive a session
  pin_check_pkg::keyRec_t mem [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= '0;
    end else if (rdEn) begin
      rdData_ff <= mem[rdAddr];
    end
  end

endmodule
`default_nettype wire

// ### verilog/pin_check_and_replace.sv
`timescale 1ns/1ns
`default_nettype none
module pin_check_and_replace #(
  parameter int NUM_KEYS = 32
) (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  // Command from the terminal
  input  wire logic                      cmdValid,
  input  wire pin_check_pkg::cmd_t       cmdIn,
  output logic                           cmdReady_ff,
  // Personalisation of a stored code
  input  wire logic                      persoValid,
  input  wire logic [pin_check_pkg::REF_W-1:0] persoRef,
  input  wire pin_check_pkg::keyRec_t    persoRec,
  // Answer
  output logic                           rspValid_ff,
  output logic [15:0]                    rspSw_ff,
  // Security status, shared by all channels
  output logic [NUM_KEYS-1:0]            securityOk_ff
);

  typedef enum {
    ST_IDLE,
    ST_EVAL,
    ST_RESP
  } state_t;

  state_t                               state_ff;
  state_t                               nxt_state;
  pin_check_pkg::cmd_t                  cmd_ff;
  pin_check_pkg::keyRec_t               rdRec;
  pin_check_pkg::keyRec_t               nxt_rec;
  pin_check_pkg::keyRec_t               memWrRec_ff;
  logic [pin_check_pkg::REF_W-1:0]      memWrRef_ff;
  logic [pin_check_pkg::REF_W-1:0]      keyRef;
  logic                                 memWr_ff;
  logic                                 take;
  logic                                 persoTake;
  logic                                 inEval;
  logic                                 blocked;
  logic                                 match;
  logic                                 isQuery;
  logic                                 presents;
  logic                                 nxt_wr;
  logic                                 nxt_grant;
  logic                                 nxt_fail;
  logic [15:0]                          nxt_sw;
  logic [15:0]                          takeSw;

  // Answer for a malformed command, or SW_OK when it may proceed
  function automatic logic [15:0] paramSw(pin_check_pkg::cmd_t c);
    logic [15:0] sw;
    sw = pin_check_pkg::SW_OK;
    if (c.p2 == pin_check_pkg::P2_UNSUPP) begin
      sw = pin_check_pkg::SW_BAD_P1P2;
    end else if ((c.p2 & pin_check_pkg::P2_RFU_MASK) != 8'h00) begin
      sw = pin_check_pkg::SW_BAD_P1P2;
    end else if (c.op == pin_check_pkg::OP_ACCESS) begin
      sw = pin_check_pkg::SW_OK;
    end else if (c.p1 != pin_check_pkg::P1_PLAIN) begin
      sw = pin_check_pkg::SW_BAD_P1P2;
    end else if (c.op == pin_check_pkg::OP_CHECK) begin
      if (c.lc != pin_check_pkg::LC_QUERY && c.lc != pin_check_pkg::LC_CHECK) begin
        sw = pin_check_pkg::SW_BAD_LEN;
      end
    end else if (c.op == pin_check_pkg::OP_REPLACE) begin
      if (c.lc != pin_check_pkg::LC_REPLACE) begin
        sw = pin_check_pkg::SW_BAD_LEN;
      end
    end else begin
      sw = pin_check_pkg::SW_BAD_P1P2;
    end
    return sw;
  endfunction

  function automatic logic [15:0] triesSw(logic [1:0] t);
    return pin_check_pkg::SW_TRIES | {14'h0000, t};
  endfunction

  // Personalisation wins the slot so a fresh code is never raced by a check
  assign take      = cmdValid && cmdReady_ff && !persoValid;
  assign persoTake = persoValid && cmdReady_ff;
  assign takeSw    = paramSw(cmdIn);
  assign inEval    = (state_ff == ST_EVAL);
  assign keyRef    = cmd_ff.p2[pin_check_pkg::REF_W-1:0]; // [RQ13]
  assign blocked   = (rdRec.tries == pin_check_pkg::TRIES_NONE);
  assign match     = (rdRec.code == cmd_ff.data[2*pin_check_pkg::CODE_W-1:pin_check_pkg::CODE_W]);
  assign isQuery   = (cmd_ff.op == pin_check_pkg::OP_CHECK) &&
                     (cmd_ff.lc == pin_check_pkg::LC_QUERY);
  assign presents  = inEval && !isQuery && (cmd_ff.op != pin_check_pkg::OP_ACCESS);

  code_store #(
    .DEPTH (NUM_KEYS),
    .AW    (pin_check_pkg::REF_W)
  ) u_store (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .rdEn      (take),
    .rdAddr    (cmdIn.p2[pin_check_pkg::REF_W-1:0]), // [RQ13]
    .rdData_ff (rdRec),
    .wrEn      (memWr_ff),
    .wrAddr    (memWrRef_ff),
    .wrData    (memWrRec_ff)
  );

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (persoTake) begin
          nxt_state = ST_RESP;
        end else if (take) begin
          nxt_state = (takeSw == pin_check_pkg::SW_OK) ? ST_EVAL : ST_RESP;
        end
      end
      ST_EVAL: begin
        nxt_state = ST_RESP;
      end
      ST_RESP: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    nxt_rec   = rdRec;
    nxt_wr    = 1'b0;
    nxt_grant = 1'b0;
    nxt_fail  = 1'b0;
    nxt_sw    = pin_check_pkg::SW_OK;
    case (cmd_ff.op)
      pin_check_pkg::OP_ACCESS: begin
        if (blocked) begin
          nxt_sw = pin_check_pkg::SW_DENIED; // [RQ10]
        end else if (!rdRec.disabled && !securityOk_ff[keyRef]) begin
          nxt_sw = pin_check_pkg::SW_DENIED; // [RQ2]
        end
      end
      pin_check_pkg::OP_CHECK,
      pin_check_pkg::OP_REPLACE: begin
        if (isQuery) begin
          nxt_sw = triesSw(rdRec.tries); // [RQ11]
        end else if (rdRec.disabled) begin
          nxt_sw = pin_check_pkg::SW_DISABLED; // [RQ1] [RQ16]
        end else if (blocked) begin
          nxt_sw = pin_check_pkg::SW_BLOCKED; // [RQ9]
        end else if (match) begin
          nxt_rec.tries = pin_check_pkg::TRIES_INIT; // [RQ3] [RQ17]
          nxt_wr        = 1'b1;
          nxt_grant     = (cmd_ff.op == pin_check_pkg::OP_CHECK);
          if (cmd_ff.op == pin_check_pkg::OP_REPLACE) begin
            nxt_rec.code = cmd_ff.data[pin_check_pkg::CODE_W-1:0]; // [RQ15]
          end
        end else begin
          // Reaching zero is the blocked state itself
          nxt_rec.tries = rdRec.tries - pin_check_pkg::TRIES_STEP; // [RQ4] [RQ18]
          nxt_wr        = 1'b1;
          nxt_fail      = 1'b1;
          nxt_sw        = triesSw(nxt_rec.tries); // [RQ6] [RQ7] [RQ8]
        end
      end
      default: begin
        nxt_sw = pin_check_pkg::SW_BAD_P1P2;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdReady_ff <= 1'b0;
    end else begin
      cmdReady_ff <= (nxt_state == ST_IDLE);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ff <= '0;
    end else if (take) begin
      cmd_ff <= cmdIn;
    end
  end

  // Malformed commands answer at once and never write the store
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rspValid_ff <= 1'b0;
      rspSw_ff    <= 16'h0000;
    end else if (take && takeSw != pin_check_pkg::SW_OK) begin
      rspValid_ff <= 1'b1;
      rspSw_ff    <= takeSw; // [RQ12] [RQ20]
    end else if (inEval) begin
      rspValid_ff <= 1'b1;
      rspSw_ff    <= nxt_sw;
    end else begin
      rspValid_ff <= 1'b0;
    end
  end

  // Write lands during RESP, before the next command can read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      memWr_ff    <= 1'b0;
      memWrRef_ff <= '0;
      memWrRec_ff <= '0;
    end else if (persoTake) begin
      memWr_ff    <= 1'b1;
      memWrRef_ff <= persoRef;
      memWrRec_ff <= persoRec;
    end else if (inEval) begin
      memWr_ff    <= nxt_wr;
      memWrRef_ff <= keyRef;
      memWrRec_ff <= nxt_rec;
    end else begin
      memWr_ff    <= 1'b0;
    end
  end

  // One flag per code, not per channel; personalising a code or a wrong check or replace drops it, a good replace keeps it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      securityOk_ff <= '0;
    end else if (persoTake) begin
      securityOk_ff[persoRef] <= 1'b0;
    end else if (inEval && nxt_grant) begin
      securityOk_ff[keyRef] <= 1'b1; // [RQ5]
    end else if (inEval && nxt_fail) begin
      securityOk_ff[keyRef] <= 1'b0;
    end
  end

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  chk_gate_state: assert property ( // [RQ1] [RQ16]
    presents && (rdRec.disabled || blocked) |=> rspValid_ff && !memWr_ff
  ) else $error("disabled or blocked code was evaluated");

  chk_pass_restore: assert property ( // [RQ3] [RQ17]
    presents && !rdRec.disabled && !blocked && match
    |=> memWr_ff && memWrRec_ff.tries == 2'h3 && rspSw_ff == 16'h9000
  ) else $error("good code did not restore three tries");

  chk_fail_count: assert property ( // [RQ4] [RQ18]
    presents && !rdRec.disabled && !blocked && !match
    |=> memWr_ff && memWrRec_ff.tries == $past(rdRec.tries) - 2'h1
        && memWrRec_ff.code == $past(rdRec.code)
  ) else $error("wrong code not counted or code altered");

  chk_sw_two: assert property ( // [RQ6]
    presents && !rdRec.disabled && !match && rdRec.tries == 2'h3
    |=> rspSw_ff == 16'h63C2
  ) else $error("first failure not answered 63C2");

  chk_sw_one: assert property ( // [RQ7]
    presents && !rdRec.disabled && !match && rdRec.tries == 2'h2
    |=> rspSw_ff == 16'h63C1
  ) else $error("second failure not answered 63C1");

  chk_block_third: assert property ( // [RQ8]
    presents && !rdRec.disabled && !match && rdRec.tries == 2'h1
    |=> rspSw_ff == 16'h63C0 && memWrRec_ff.tries == 2'h0 ##1 !memWr_ff
  ) else $error("third failure did not block");

  chk_blocked_sw: assert property ( // [RQ9]
    presents && !rdRec.disabled && blocked |=> rspSw_ff == 16'h6983
  ) else $error("blocked code not answered 6983");

  chk_access_gate: assert property ( // [RQ2] [RQ10]
    inEval && cmd_ff.op == pin_check_pkg::OP_ACCESS
    && (blocked || (!rdRec.disabled && !securityOk_ff[keyRef]))
    |=> rspValid_ff && rspSw_ff == 16'h6982
  ) else $error("access granted without status");

  chk_query_tries: assert property ( // [RQ11]
    inEval && isQuery
    |=> rspSw_ff == (16'h63C0 | {14'h0000, $past(rdRec.tries)}) && !memWr_ff
  ) else $error("query answer wrong or state touched");

  chk_bad_param: assert property ( // [RQ12] [RQ20]
    take && cmdIn.p2 == 8'h00
    |=> rspValid_ff && rspSw_ff == 16'h6A86 && !memWr_ff ##1 cmdReady_ff
  ) else $error("zero parameter byte 2 not rejected");

  chk_replace_new: assert property ( // [RQ15]
    presents && cmd_ff.op == pin_check_pkg::OP_REPLACE
    && !rdRec.disabled && !blocked && match
    |=> memWrRec_ff.code == $past(cmd_ff.data[63:0])
  ) else $error("new code not stored");

  chk_status_set: assert property ( // [RQ5]
    presents && cmd_ff.op == pin_check_pkg::OP_CHECK
    && !rdRec.disabled && !blocked && match
    |=> securityOk_ff[$past(keyRef)]
  ) else $error("security status not set");

  chk_answer_lat: assert property ( // [RQ13]
    take && takeSw == pin_check_pkg::SW_OK ##1 1'b1 |-> ##1 rspValid_ff
  ) else $error("answer not two cycles after take");

  // Catches a key index taken from the wrong bits of parameter byte 2
  chk_key_write: assert property ( // [RQ13]
    inEval && nxt_wr |=> memWr_ff && memWrRef_ff == $past(cmd_ff.p2[4:0])
  ) else $error("store written at wrong key index");

  chk_rfu_param: assert property ( // [RQ12] [RQ20]
    take && (cmdIn.p2 & pin_check_pkg::P2_RFU_MASK) != 8'h00
    |=> rspValid_ff && rspSw_ff == 16'h6A86 && !memWr_ff
  ) else $error("reserved parameter bits not rejected");

  chk_access_open: assert property ( // [RQ2]
    inEval && cmd_ff.op == pin_check_pkg::OP_ACCESS && !blocked
    && (rdRec.disabled || securityOk_ff[keyRef])
    |=> rspValid_ff && rspSw_ff == 16'h9000
  ) else $error("access refused despite status");

  // Only an evaluation or a personalisation may touch the store
  chk_store_quiet: assert property ( // [RQ20]
    !inEval && !persoTake |=> !memWr_ff
  ) else $error("store written outside evaluation");

  cov_query: cover property (inEval && isQuery && blocked);
  cov_block: cover property (presents && !match && rdRec.tries == 2'h1);
  cov_replace: cover property (
    presents && cmd_ff.op == pin_check_pkg::OP_REPLACE && match && !blocked);
  cov_access: cover property (
    inEval && cmd_ff.op == pin_check_pkg::OP_ACCESS ##1 rspSw_ff == 16'h9000);
  cov_reject: cover property (take && takeSw != pin_check_pkg::SW_OK);

endmodule
`default_nettype wire

// ### verilog/pin_check_pkg.sv
// Contract
// [RQ1] Check a code only while it is neither disabled nor blocked.
// [RQ2] An access tied to a code needs a prior good check, unless disabled.
// [RQ3] A correct check restores the code's remaining tries to three.
// [RQ4] A wrong check decrements the code's tries, whatever channel carried it.
// [RQ5] A good check sets a security status valid on every channel.
// [RQ6] First wrong presentation answers 63C2.
// [RQ7] Second consecutive wrong answers 63C1; tries are kept across power-ups.
// [RQ8] Third consecutive wrong blocks the code and answers 63C0.
// [RQ9] A blocked code answers any check carrying code data with 6983.
// [RQ10] Access tied to a blocked code is never granted until released.
// [RQ11] Check with empty data answers 63CX, even when disabled or blocked.
// [RQ12] Parameter byte 2: bit 8 global/specific, bits 7-6 zero, zero unsupported.
// [RQ13] The five low bits of parameter byte 2 select the code.
// [RQ14] Terminal sends check with P1 00, length empty or 08, no Le.
// [RQ15] Replace compares old code, then stores new one for all channels.
// [RQ16] Replace runs only while the code is neither disabled nor blocked.
// [RQ17] Replace with correct old code restores three tries and stores new code.
// [RQ18] Replace with wrong old code decrements tries and keeps stored code.
// [RQ19] Terminal sends replace with length 10 hex, old then new code, P1 00.
// [RQ20] Bad parameter byte 2 is rejected without touching any state.
package pin_check_pkg;

  localparam int REF_W  = 5;
  localparam int CODE_W = 64;

  localparam logic [1:0] TRIES_INIT = 2'h3;
  localparam logic [1:0] TRIES_NONE = 2'h0;
  localparam logic [1:0] TRIES_STEP = 2'h1;

  localparam logic [7:0] P1_PLAIN    = 8'h00;
  localparam logic [7:0] LC_QUERY    = 8'h00;
  localparam logic [7:0] LC_CHECK    = 8'h08;
  localparam logic [7:0] LC_REPLACE  = 8'h10;
  localparam logic [7:0] P2_UNSUPP   = 8'h00;
  localparam logic [7:0] P2_RFU_MASK = 8'h60;
  localparam int         P2_SPEC_BIT = 7;

  localparam logic [15:0] SW_OK        = 16'h9000;
  localparam logic [15:0] SW_TRIES     = 16'h63C0;
  localparam logic [15:0] SW_BLOCKED   = 16'h6983;
  localparam logic [15:0] SW_DISABLED  = 16'h6984;
  localparam logic [15:0] SW_DENIED    = 16'h6982;
  localparam logic [15:0] SW_BAD_P1P2  = 16'h6A86;
  localparam logic [15:0] SW_BAD_LEN   = 16'h6700;

  typedef enum logic [1:0] {
    OP_CHECK,
    OP_REPLACE,
    OP_ACCESS
  } op_t;

  // Data byte 1 sits in the top byte of data
  typedef struct packed {
    op_t               op;
    logic [7:0]        p1;
    logic [7:0]        p2;
    logic [7:0]        lc;
    logic [2*CODE_W-1:0] data;
  } cmd_t;

  typedef struct packed {
    logic              disabled;
    logic [1:0]        tries;
    logic [CODE_W-1:0] code;
  } keyRec_t;

endpackage
